//--- pkg/cts_pkg.sv
// Package for the chain transfer sequencer: map, descriptor layout, types
package cts_pkg;
    localparam int          NUM_SRC       = 4;
    localparam int          SRC_W         = 2;
    // Vector number of source 0; sources follow consecutively
    localparam logic [7:0]  VEC_FIRST     = 8'h40;
    // Register word indices (compared with address[3:2])
    localparam logic [1:0]  REG_CTRL      = 2'h0;
    localparam logic [1:0]  REG_VBASE     = 2'h1;
    localparam logic [1:0]  REG_ACT_EN    = 2'h2;
    localparam logic [1:0]  REG_STATUS    = 2'h3;
    // Control register fields
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_RSE      = 1;
    // Reset values
    localparam logic [31:0] VBASE_RST     = 32'h0000_0000;
    localparam logic        START_RST     = 1'b0;
    localparam logic        RSE_RST       = 1'b0;
    localparam logic        WAIT_RST      = 1'b1;
    // Descriptor word 0 (mode_register_b bits included)
    localparam int          MD_HI         = 31;
    localparam int          MD_LO         = 30;
    localparam int          SM_HI         = 27;
    localparam int          SM_LO         = 26;
    localparam int          DM_HI         = 25;
    localparam int          DM_LO         = 24;
    localparam int          CHAIN_ENABLE_BIT_BIT      = 23;
    localparam int          CHAIN_CONDITION_SELECT_BIT      = 22;
    localparam int          PER_TRANSFER_IRQ_SELECT_BIT     = 21;
    localparam int          DTS_BIT       = 20;
    // Transfer modes and address operations
    localparam logic [1:0]  MD_NORMAL     = 2'h0;
    localparam logic [1:0]  MD_REPEAT     = 2'h1;
    localparam logic [1:0]  MD_BLOCK      = 2'h2;
    localparam logic [1:0]  AOP_INC       = 2'h2;
    localparam logic [1:0]  AOP_DEC       = 2'h3;
    localparam logic [31:0] UNIT_BYTES    = 32'h0000_0004;
    localparam logic [31:0] DESC_BYTES    = 32'h0000_0010;
    localparam logic [1:0]  DESC_LAST_IDX = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_VEC, ST_DESC, ST_START, ST_DRD, ST_DWR, ST_WB, ST_END
    } cts_state_t;

    // Avalon-MM slave request and answer
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } cts_avs_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } cts_avs_rsp_t;

    // Memory master request and answer (ack is a one-cycle pulse)
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cts_mem_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } cts_mem_rsp_t;
endpackage

//--- hdl/cts_sequencer.sv
// Chain transfer sequencer: activation, descriptor fetch, move, chain, end
`timescale 1ns/1ps
module cts_sequencer (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_i,
    input  wire cts_pkg::cts_avs_req_t         avs_req_i,
    output logic                               avs_waitrequest_o,
    output logic [31:0]                        avs_readdata_o,
    output cts_pkg::cts_mem_req_t              mem_req_o,
    input  wire cts_pkg::cts_mem_rsp_t         mem_rsp_i,
    input  wire logic [cts_pkg::NUM_SRC-1:0]   src_flag_i,
    output logic [cts_pkg::NUM_SRC-1:0]        src_flag_clr_o,
    output logic [cts_pkg::NUM_SRC-1:0]        cpu_irq_o,
    output logic                               busy_o
);

    typedef struct packed {
        cts_pkg::cts_state_t                st;
        cts_pkg::cts_avs_rsp_t              avs;
        cts_pkg::cts_mem_req_t              mem;
        logic                               start;
        logic                               rse;
        logic [31:0]                        vbase;
        logic [cts_pkg::NUM_SRC-1:0]        act_en;
        logic [cts_pkg::NUM_SRC-1:0]        pend;
        logic [cts_pkg::NUM_SRC-1:0]        flag_prev;
        logic [cts_pkg::NUM_SRC-1:0]        flag_clr;
        logic [cts_pkg::NUM_SRC-1:0]        irq;
        logic [cts_pkg::SRC_W-1:0]          src;
        logic                               skip_valid;
        logic [cts_pkg::SRC_W-1:0]          skip_src;
        logic [31:0]                        skip_ptr;
        logic [31:0]                        dptr;
        logic [1:0]                         idx;
        logic [31:0]                        mode;
        logic [31:0]                        sar;
        logic [31:0]                        dar;
        logic [31:0]                        cnt;
        logic [31:0]                        data;
        logic                               last;
        logic                               busy;
    } cts_regs_t;
    cts_regs_t s_q;
    cts_regs_t s_d;

    // Byte-lane merge of a register write
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction
    // Address update after one data unit
    function automatic logic [31:0] step_addr(input logic [31:0] a,
                                              input logic [1:0]  op);
        logic [31:0] r;
        r = a;
        if (op == cts_pkg::AOP_INC) begin
            r = a + cts_pkg::UNIT_BYTES;
        end else if (op == cts_pkg::AOP_DEC) begin
            r = a - cts_pkg::UNIT_BYTES;
        end
        return r;
    endfunction
    // Distance walked over one block or repeat area (size 0 means 256)
    function automatic logic [31:0] area_span(input logic [7:0] size,
                                              input logic [1:0] op);
        logic [31:0] span;
        span = {21'h0, (size == 8'h00), size, 2'h0};
        if (op == cts_pkg::AOP_INC) begin
            return span;
        end else if (op == cts_pkg::AOP_DEC) begin
            return -span;
        end
        return 32'h0000_0000;
    endfunction
    logic [1:0]  md;
    logic [1:0]  sm;
    logic [1:0]  dm;
    logic        chain_enable_bit;
    logic        chain_condition_select;
    logic        per_transfer_irq_select;
    logic        dts;
    logic        at_one;
    logic        chain_go;
    logic [7:0]  cra_hi;
    logic [7:0]  cra_lo;
    logic [15:0] transfer_counter_a;
    logic [15:0] block_transfer_counter;
    logic [31:0] mux_rd;
    // Descriptor field decode
    always_comb begin
        md     = s_q.mode[cts_pkg::MD_HI:cts_pkg::MD_LO];
        sm     = s_q.mode[cts_pkg::SM_HI:cts_pkg::SM_LO];
        dm     = s_q.mode[cts_pkg::DM_HI:cts_pkg::DM_LO];
        chain_enable_bit   = s_q.mode[cts_pkg::CHAIN_ENABLE_BIT_BIT];
        chain_condition_select   = s_q.mode[cts_pkg::CHAIN_CONDITION_SELECT_BIT];
        per_transfer_irq_select  = s_q.mode[cts_pkg::PER_TRANSFER_IRQ_SELECT_BIT];
        dts    = s_q.mode[cts_pkg::DTS_BIT];
        transfer_counter_a    = s_q.cnt[31:16];
        cra_hi = s_q.cnt[31:24];
        cra_lo = s_q.cnt[23:16];
        block_transfer_counter    = s_q.cnt[15:0];
        // Counter that will step from one on this transfer
        case (md)
            cts_pkg::MD_NORMAL: at_one = (transfer_counter_a == 16'h0001);
            cts_pkg::MD_REPEAT: at_one = (cra_lo == 8'h01);
            default:            at_one = (block_transfer_counter == 16'h0001);
        endcase
        chain_go = chain_enable_bit && (!chain_condition_select || s_q.last);
        case (s_q.avs.waitrequest ? avs_req_i.address[3:2] : 2'h0)
            cts_pkg::REG_CTRL:   mux_rd = {30'h0, s_q.rse, s_q.start};
            cts_pkg::REG_VBASE:  mux_rd = s_q.vbase;
            cts_pkg::REG_ACT_EN: mux_rd = {28'h0, s_q.act_en};
            default:             mux_rd = {24'h0, s_q.pend, s_q.skip_valid,
                                           s_q.src, s_q.busy};
        endcase
    end

    // Next-state logic: bus slave, activation latch and sequencer
    always_comb begin
        s_d          = s_q;
        s_d.flag_clr = '0;
        s_d.irq      = '0;
        s_d.avs.waitrequest = 1'b1;
        s_d.flag_prev = src_flag_i;
        // Register slave: answer one cycle after the request appears
        if ((avs_req_i.read || avs_req_i.write) && s_q.avs.waitrequest) begin
            s_d.avs.waitrequest = 1'b0;
            s_d.avs.readdata    = avs_req_i.read ? mux_rd : 32'h0;
        end
        if (avs_req_i.write && !s_q.avs.waitrequest) begin
            case (avs_req_i.address[3:2])
                cts_pkg::REG_CTRL: begin
                    if (avs_req_i.byteenable[0]) begin
                        s_d.start = avs_req_i.writedata[cts_pkg::CTRL_START];
                        s_d.rse   = avs_req_i.writedata[cts_pkg::CTRL_RSE];
                        if (!avs_req_i.writedata[cts_pkg::CTRL_RSE]) begin
                            s_d.skip_valid = 1'b0;
                        end
                    end
                end
                cts_pkg::REG_VBASE: s_d.vbase = be_merge(s_q.vbase,
                    avs_req_i.writedata, avs_req_i.byteenable);
                cts_pkg::REG_ACT_EN: begin
                    if (avs_req_i.byteenable[0]) begin
                        s_d.act_en = avs_req_i.writedata[cts_pkg::NUM_SRC-1:0];
                    end
                end
                default: ;
            endcase
        end
        // Pending latch per source; a new rising edge beats the service
        for (int i = 0; i < cts_pkg::NUM_SRC; i++) begin
            if (!s_q.busy && s_q.start && s_q.pend[i] &&
                (s_q.pend & ((1 << i) - 1)) == '0) begin
                s_d.pend[i] = 1'b0;
            end
            if (src_flag_i[i] && !s_q.flag_prev[i] && s_q.act_en[i]) begin
                s_d.pend[i] = 1'b1;
            end
        end
        case (s_q.st)
            cts_pkg::ST_IDLE: begin
                // Lowest numbered pending source is served first
                for (int i = cts_pkg::NUM_SRC - 1; i >= 0; i--) begin
                    if (s_q.start && s_q.pend[i]) begin
                        s_d.src = i[cts_pkg::SRC_W-1:0];
                        s_d.st  = cts_pkg::ST_VEC;
                    end
                end
            end
            cts_pkg::ST_VEC: begin
                // Vector read is skipped when the same source repeats
                if (s_q.rse && s_q.skip_valid && s_q.skip_src == s_q.src) begin
                    s_d.dptr = s_q.skip_ptr;
                    s_d.idx  = 2'h0;
                    s_d.st   = cts_pkg::ST_DESC;
                end else if (!s_q.mem.req) begin
                    s_d.mem.req  = 1'b1;
                    s_d.mem.we   = 1'b0;
                    s_d.mem.addr = s_q.vbase + {22'h0,
                        cts_pkg::VEC_FIRST + 8'(s_q.src), 2'h0};
                end else if (mem_rsp_i.ack) begin
                    s_d.mem.req    = 1'b0;
                    s_d.dptr       = mem_rsp_i.rdata;
                    s_d.skip_ptr   = mem_rsp_i.rdata;
                    s_d.skip_src   = s_q.src;
                    s_d.skip_valid = s_q.rse;
                    s_d.idx        = 2'h0;
                    s_d.st         = cts_pkg::ST_DESC;
                end
            end
            cts_pkg::ST_DESC: begin
                // Four descriptor words from the descriptor pointer
                if (!s_q.mem.req) begin
                    s_d.mem.req  = 1'b1;
                    s_d.mem.we   = 1'b0;
                    s_d.mem.addr = s_q.dptr + {28'h0, s_q.idx, 2'h0};
                end else if (mem_rsp_i.ack) begin
                    s_d.mem.req = 1'b0;
                    case (s_q.idx)
                        2'h0:    s_d.mode = mem_rsp_i.rdata;
                        2'h1:    s_d.sar  = mem_rsp_i.rdata;
                        2'h2:    s_d.dar  = mem_rsp_i.rdata;
                        default: s_d.cnt  = mem_rsp_i.rdata;
                    endcase
                    s_d.idx = s_q.idx + 2'h1;
                    if (s_q.idx == cts_pkg::DESC_LAST_IDX) begin
                        s_d.st = cts_pkg::ST_START;
                    end
                end
            end
            cts_pkg::ST_START: begin
                // Test the counter before the step; chain decision uses it
                s_d.last = at_one;
                if (!(at_one && md != cts_pkg::MD_REPEAT) && !per_transfer_irq_select) begin
                    s_d.flag_clr[s_q.src] = 1'b1;
                end                                     // else flag kept
                s_d.st = cts_pkg::ST_DRD;
            end
            cts_pkg::ST_DRD: begin
                if (!s_q.mem.req) begin
                    s_d.mem.req  = 1'b1;
                    s_d.mem.we   = 1'b0;
                    s_d.mem.addr = s_q.sar;
                end else if (mem_rsp_i.ack) begin
                    s_d.mem.req = 1'b0;
                    s_d.data    = mem_rsp_i.rdata;
                    s_d.st      = cts_pkg::ST_DWR;
                end
            end
            cts_pkg::ST_DWR: begin
                if (!s_q.mem.req) begin
                    s_d.mem.req   = 1'b1;
                    s_d.mem.we    = 1'b1;
                    s_d.mem.addr  = s_q.dar;
                    s_d.mem.wdata = s_q.data;
                end else if (mem_rsp_i.ack) begin
                    s_d.mem.req = 1'b0;
                    s_d.sar     = step_addr(s_q.sar, sm);
                    s_d.dar     = step_addr(s_q.dar, dm);
                    s_d.idx     = 2'h1;
                    s_d.st      = cts_pkg::ST_WB;
                    case (md)
                        cts_pkg::MD_NORMAL: s_d.cnt[31:16] = transfer_counter_a - 16'h1;
                        cts_pkg::MD_REPEAT: begin
                            if (cra_lo == 8'h01) begin
                                // Reload count, rewind the repeat area
                                s_d.cnt[23:16] = cra_hi;
                                if (dts) begin
                                    s_d.sar = step_addr(s_q.sar, sm) -
                                              area_span(cra_hi, sm);
                                end else begin
                                    s_d.dar = step_addr(s_q.dar, dm) -
                                              area_span(cra_hi, dm);
                                end
                            end else begin
                                s_d.cnt[23:16] = cra_lo - 8'h1;
                            end
                        end
                        default: begin
                            s_d.cnt[23:16] = cra_lo - 8'h1;
                            if (cra_lo != 8'h01) begin
                                s_d.st = cts_pkg::ST_DRD; // More units
                            end else begin
                                s_d.cnt[23:16] = cra_hi;
                                s_d.cnt[15:0]  = block_transfer_counter - 16'h1;
                                if (dts) begin
                                    s_d.sar = step_addr(s_q.sar, sm) -
                                              area_span(cra_hi, sm);
                                end else begin
                                    s_d.dar = step_addr(s_q.dar, dm) -
                                              area_span(cra_hi, dm);
                                end
                            end
                        end
                    endcase
                end
            end
            cts_pkg::ST_WB: begin
                // Write back address and counter words of the descriptor
                if (!s_q.mem.req) begin
                    s_d.mem.req  = 1'b1;
                    s_d.mem.we   = 1'b1;
                    s_d.mem.addr = s_q.dptr + {28'h0, s_q.idx, 2'h0};
                    case (s_q.idx)
                        2'h1:    s_d.mem.wdata = s_q.sar;
                        2'h2:    s_d.mem.wdata = s_q.dar;
                        default: s_d.mem.wdata = s_q.cnt;
                    endcase
                end else if (mem_rsp_i.ack) begin
                    s_d.mem.req = 1'b0;
                    s_d.idx     = s_q.idx + 2'h1;
                    if (s_q.idx == cts_pkg::DESC_LAST_IDX) begin
                        s_d.st = cts_pkg::ST_END;
                    end
                end
            end
            cts_pkg::ST_END: begin
                if (chain_go) begin
                    // Next descriptor sits right after this one
                    s_d.dptr = s_q.dptr + cts_pkg::DESC_BYTES;
                    s_d.idx  = 2'h0;
                    s_d.st   = cts_pkg::ST_DESC;
                end else begin
                    if (s_q.last && md != cts_pkg::MD_REPEAT) begin
                        s_d.act_en[s_q.src] = 1'b0;
                        s_d.irq[s_q.src]    = 1'b1;
                    end else if (per_transfer_irq_select) begin
                        s_d.irq[s_q.src]    = 1'b1;     // only at chain end
                    end                                 // else enable kept
                    s_d.st = cts_pkg::ST_IDLE;
                end
            end
            default: s_d.st = cts_pkg::ST_IDLE;
        endcase
        // Busy is kept in a flop so the output has no decode behind it
        s_d.busy = (s_d.st != cts_pkg::ST_IDLE);
    end
    // State register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q                 <= '0;
            s_q.avs.waitrequest <= cts_pkg::WAIT_RST;
            s_q.vbase           <= cts_pkg::VBASE_RST;
            s_q.start           <= cts_pkg::START_RST;
            s_q.rse             <= cts_pkg::RSE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign avs_waitrequest_o = s_q.avs.waitrequest;
    assign avs_readdata_o    = s_q.avs.readdata;
    assign mem_req_o         = s_q.mem;
    assign src_flag_clr_o    = s_q.flag_clr;
    assign cpu_irq_o         = s_q.irq;
    assign busy_o            = s_q.busy;
endmodule // cts_sequencer

//--- verification/cts_mem_model.sv
// Far-side model: on-chip RAM with slow or prompt answers, source flags
`timescale 1ns/1ps
module cts_mem_model (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  slow_i,
    input  wire cts_pkg::cts_mem_req_t req_i,
    output cts_pkg::cts_mem_rsp_t      rsp_o,
    input  wire logic [3:0]            set_i,
    input  wire logic [3:0]            clr_i,
    input  wire logic [3:0]            irq_i,
    output logic [3:0]                 flag_o
);
    logic [31:0] mem [0:255];
    logic [1:0]  wait_q;
    // Answer after zero or three wait cycles, data changes when released
    always @(posedge clk_sys_i) begin
        rsp_o.ack   <= 1'b0;
        rsp_o.rdata <= ~rsp_o.rdata;
        if (rst_i) begin
            rsp_o  <= '0;
            wait_q <= 2'h0;
        end else if (req_i.req && !rsp_o.ack) begin
            if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
                wait_q      <= 2'h0;
                rsp_o.ack   <= 1'b1;
                rsp_o.rdata <= mem[req_i.addr[9:2]];
                if (req_i.we) mem[req_i.addr[9:2]] <= req_i.wdata;
            end else wait_q <= wait_q + 2'h1;
        end
        // Accepted interrupt clears the flag, a new event wins
        flag_o <= rst_i ? 4'h0 : (flag_o & ~clr_i & ~irq_i) | set_i;
    end
endmodule // cts_mem_model

//--- verification/cts_sequencer_props.sv
// Port checker of the chain transfer sequencer and its bind
`timescale 1ns/1ps
module cts_sequencer_props (
    input wire logic                        clk_sys_i,
    input wire logic                        rst_i,
    input wire cts_pkg::cts_avs_req_t       avs_req_i,
    input wire logic                        avs_waitrequest_o,
    input wire logic [31:0]                 avs_readdata_o,
    input wire cts_pkg::cts_mem_req_t       mem_req_o,
    input wire cts_pkg::cts_mem_rsp_t       mem_rsp_i,
    input wire logic [cts_pkg::NUM_SRC-1:0] src_flag_i,
    input wire logic [cts_pkg::NUM_SRC-1:0] src_flag_clr_o,
    input wire logic [cts_pkg::NUM_SRC-1:0] cpu_irq_o,
    input wire logic                        busy_o
);
    logic [31:0] vbase_q;
    logic        rse_q;
    // Shadow of vector base and read-skip enable from accepted writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            vbase_q <= 32'h0;
            rse_q   <= 1'b0;
        end else if (avs_req_i.write && !avs_waitrequest_o) begin
            if (avs_req_i.address[3:2] == cts_pkg::REG_VBASE)
                vbase_q <= avs_req_i.writedata;
            if (avs_req_i.address[3:2] == cts_pkg::REG_CTRL)
                rse_q <= avs_req_i.writedata[cts_pkg::CTRL_RSE];
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    bus_answer_a: assert property ((avs_req_i.read || avs_req_i.write)
        && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
    mem_hold_a: assert property (mem_req_o.req && !mem_rsp_i.ack |=>
        mem_req_o.req && $stable(mem_req_o.addr)) else $error("req moved");
    mem_drop_a: assert property (mem_rsp_i.ack |=> !mem_req_o.req)
        else $error("req kept after ack");
    irq_pulse_a: assert property (|cpu_irq_o |=> cpu_irq_o == 4'h0)
        else $error("irq not a pulse");
    irq_end_a: assert property (|cpu_irq_o |-> ##[0:3] !busy_o)
        else $error("irq before chain end");
    clr_pulse_a: assert property (|src_flag_clr_o |->
        busy_o ##1 src_flag_clr_o == 4'h0) else $error("bad flag clear");
    idle_quiet_a: assert property (!busy_o |-> !mem_req_o.req)
        else $error("memory access while idle");
    vec_slot_a: assert property ($rose(busy_o) && !rse_q |-> ##[0:4]
        (mem_req_o.req && (mem_req_o.addr - vbase_q) inside
        {32'h100, 32'h104, 32'h108, 32'h10c})) else $error("no vector read");
    cover property (|cpu_irq_o);
    cover property (|src_flag_clr_o);
    cover property ($rose(busy_o) && rse_q);
endmodule // cts_sequencer_props
bind cts_sequencer cts_sequencer_props i_props (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .avs_req_i(avs_req_i), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_readdata_o(avs_readdata_o), .mem_req_o(mem_req_o),
    .mem_rsp_i(mem_rsp_i), .src_flag_i(src_flag_i),
    .src_flag_clr_o(src_flag_clr_o), .cpu_irq_o(cpu_irq_o), .busy_o(busy_o));

//--- verification/tb.sv
// Bench: table of transfer cases, reset-value and read-skip checks
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [31:0] w0, w3, wb;
        logic [3:0]  clr, irq, xfer;
        logic        act;
    } cts_row_t;
    // Word 0, word 3, written-back word 3, pulses, transfers, enable
    cts_row_t rows [8] = '{
        '{32'h0a000000, 32'h00020000, 32'h00010000, 4'h1, 4'h0, 4'h1, 1'b1},
        '{32'h0a000000, 32'h00010000, 32'h00000000, 4'h0, 4'h1, 4'h1, 1'b0},
        '{32'h0a800000, 32'h00020000, 32'h00010000, 4'h1, 4'h1, 4'h2, 1'b0},
        '{32'h0ac00000, 32'h00020000, 32'h00010000, 4'h1, 4'h0, 4'h1, 1'b1},
        '{32'h0ac00000, 32'h00010000, 32'h00000000, 4'h0, 4'h1, 4'h2, 1'b0},
        '{32'h0aa00000, 32'h00010000, 32'h00000000, 4'h0, 4'h1, 4'h2, 1'b0},
        '{32'h0a200000, 32'h00020000, 32'h00010000, 4'h0, 4'h1, 4'h1, 1'b1},
        '{32'h8a100000, 32'h02020001, 32'h02020000, 4'h0, 4'h1, 4'h2, 1'b0}};
    logic                  clk_sys_i, rst_i, slow, wreq, busy;
    logic [31:0]           rdata, q;
    logic [3:0]            set_fl, flag, clr, irq;
    cts_pkg::cts_avs_req_t avs;
    cts_pkg::cts_mem_req_t mreq;
    cts_pkg::cts_mem_rsp_t mrsp;
    int                    mismatches, n_checks, n_clr, n_irq, n_xfer, n_vec;
    cts_sequencer i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_req_i(avs),
        .avs_waitrequest_o(wreq), .avs_readdata_o(rdata), .mem_req_o(mreq),
        .mem_rsp_i(mrsp), .src_flag_i(flag), .src_flag_clr_o(clr),
        .cpu_irq_o(irq), .busy_o(busy));
    cts_mem_model i_mem (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow),
        .req_i(mreq), .rsp_o(mrsp), .set_i(set_fl), .clr_i(clr), .irq_i(irq),
        .flag_o(flag));
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Count pulses of source 1, data writes and vector reads
    always @(posedge clk_sys_i) begin
        if (clr[1] === 1'b1) n_clr++;
        if (irq[1] === 1'b1) n_irq++;
        if (mrsp.ack === 1'b1 && mreq.we && mreq.addr[31:7] == 25'h7) n_xfer++;
        if (mrsp.ack === 1'b1 && !mreq.we && mreq.addr == 32'h124) n_vec++;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        avs.read       <= !wr;
        avs.write      <= wr;
        avs.address    <= a;
        avs.writedata  <= d;
        avs.byteenable <= 4'hf;
        do begin
            @(posedge clk_sys_i);
        end while (wreq !== 1'b0);
        r = rdata;
        avs.read  <= 1'b0;
        avs.write <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    // Descriptor pair at 0x200 chained to 0x210, source 1 enabled
    task automatic ld(input logic [31:0] w0, w3);
        i_mem.mem[8'h80] = w0;
        i_mem.mem[8'h81] = 32'h300;
        i_mem.mem[8'h82] = 32'h380;
        i_mem.mem[8'h83] = w3;
        i_mem.mem[8'h84] = 32'h0a000000;
        i_mem.mem[8'h85] = 32'h304;
        i_mem.mem[8'h86] = 32'h384;
        i_mem.mem[8'h87] = 32'h00010000;
        i_mem.mem[8'he0] = 32'h0;
        {n_clr, n_irq, n_xfer} = '0;
        bus(1'b1, 4'h8, 32'h2, q);
    endtask
    task automatic run;
        int n;
        n = 0;
        set_fl <= 4'h2;
        @(posedge clk_sys_i);
        set_fl <= 4'h0;
        while (busy !== 1'b1 && n < 100) begin
            @(posedge clk_sys_i);
            n++;
        end
        while (busy !== 1'b0 && n < 600) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 600) mismatches++;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #5000000;
        mismatches++;
        test_done;
    end
    initial begin
        avs = '0;
        set_fl = 4'h0;
        slow = 1'b0;
        rst_i = 1'b1;
        for (int k = 0; k < 4; k++) i_mem.mem[8'hc0 + k] = 32'hc0de0000 + k;
        i_mem.mem[8'h49] = 32'h200;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b1, 4'h4, 32'h20, q);
        bus(1'b1, 4'h0, 32'h1, q);
        foreach (rows[i]) begin
            ld(rows[i].w0, rows[i].w3);
            run;
            chk("flag_clears", rows[i].clr, n_clr);
            chk("cpu_irqs", rows[i].irq, n_irq);
            chk("transfers", rows[i].xfer, n_xfer);
            chk("write_back", rows[i].wb, i_mem.mem[8'h83]);
            chk("moved_data", 32'hc0de0000, i_mem.mem[8'he0]);
            bus(1'b0, 4'h8, 32'h0, q);
            chk("act_enable", {30'h0, rows[i].act, 1'b0}, q);
        end
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 4'(a * 4), 32'h0, q);
            chk("reset_value", 32'h0, q);
        end
        bus(1'b1, 4'hc, 32'hffffffff, q);
        bus(1'b0, 4'hc, 32'h0, q);
        chk("status_ro", 32'h0, q);
        slow <= 1'b1;
        bus(1'b1, 4'h4, 32'h20, q);
        bus(1'b1, 4'h0, 32'h3, q);
        n_vec = 0;
        ld(32'h0a000000, 32'h00050000);
        run;
        run;
        chk("vector_skip", 32'h1, n_vec);
        bus(1'b1, 4'h0, 32'h1, q);
        run;
        chk("vector_reread", 32'h2, n_vec);
        chk("count_down", 32'h00020000, i_mem.mem[8'h83]);
        test_done;
    end
endmodule // tb
